// ---- logic/bus_data_map.svh ----
// Constants for the bus data modules: offsets, reset values, timing
`ifndef BUS_DATA_MAP_SVH
`define BUS_DATA_MAP_SVH
`define REG_CTRL 4'h0
`define REG_CONST0 4'h1
`define REG_STATUS 4'h5
`define REG_HOLD 4'h6
`define REG_IO_OUT 4'h7
`define CTRL_AUTOSTART 0
`define STAT_NEG 0
`define STAT_ZERO 1
`define STAT_POS 2
`define STAT_CARRY 3
`define STAT_LINK 4
`define CONST_RST 16'hFFFF
`define AUTOSTART_RST 1'h1
`define CLK_PERIOD_NS 40
`define PWR_CLR_NS 10000
`define PWR_CLR_CYC ((`PWR_CLR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- logic/bus_data_pkg.sv ----
// Types shared by the bus data modules
package bus_data_pkg;
  typedef enum logic [4:0] {
    OP_IDLE, OP_HOLD_W_FROM_ACC, OP_HOLD_U_FROM_ACC, OP_HOLD_L_FROM_ACC,
    OP_ACC_FROM_HOLD_W, OP_ACC_FROM_HOLD_U, OP_ACC_FROM_HOLD_L,
    OP_ARG_FROM_CONST, OP_IO_FROM_ACC, OP_IO_FROM_ARG, OP_ACC_FROM_IO,
    OP_ARG_FROM_IO, OP_EXAMINE_ACC, OP_EXAMINE_ARG, OP_CLEAR_ACC,
    OP_CLEAR_ARG, OP_CLEAR_HOLD, OP_BANK_HALT, OP_FLAG_CMD, OP_LINK_LOAD,
    OP_LINK_CLEAR, OP_LINK_SET, OP_LINK_INVERT, OP_ARITH
  } op_t;
  typedef struct packed {
    op_t op;
    logic [1:0] constSel;
    logic save;
  } evoke_t;
  typedef struct packed {
    logic accSrc;
    logic argSrc;
    logic accDst;
    logic argDst;
  } gpa_evoke_t;
  typedef struct packed {
    logic negative;
    logic zero;
    logic positive;
    logic carry;
  } cond_t;
endpackage

// ---- logic/bus_data_modules.sv ----
// Holding register, constant ROM, I/O port and bus sense unit on the data bus
//
// Contract
// [RULE1] Holding register stores/returns word, upper, lower byte
// [RULE2] Holding contents read back only to accumulator
// [RULE3] Source raises ready, destination raises accept
// [RULE4] Four jumper constant words; intact jumper is one
// [RULE5] Constants go only to argument; ROM never accepts
// [RULE6] I/O port sends/receives from accumulator or argument
// [RULE7] Open-collector drivers; low line means one
// [RULE8] Accept clocks sign flags and makes completion pulse
// [RULE9] Sign bit one sets negative flag
// [RULE10] Zero flag only when all bits zero
// [RULE11] Positive flag when neither negative nor zero
// [RULE12] Flag outputs feed condition mux zero channels
// [RULE13] Examine ops: register ready, sense unit accepts
// [RULE14] Save suffix captures overflow into carry bit
// [RULE15] Carry bit feeds mux and link register
// [RULE16] Clear ops: zero gate ready, bus all zero
// [RULE17] Bank/halt and flag commands overwrite sign flags
// [RULE18] Completion pulse on every accept restarts sequencer
// [RULE19] Power clear at power-up; auto or manual start
// [RULE20] Programs re-examine registers before sign tests
// [RULE21] Capture only after both ready and accept
// [RULE22] Link supports clear, set, invert, load
// [RULE23] Bus is wired-OR of enabled sources
//
// The plain strobed port and the address map were left to the implementer.
`include "bus_data_map.svh"
`timescale 1ns/1ns
`default_nettype none
module bus_data_modules #(
  parameter int WIDTH = 16,
  parameter int PWR_CLR_CYCLES = `PWR_CLR_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire bus_data_pkg::evoke_t evoke,
  input wire logic [WIDTH-1:0] busLevel,
  output logic [WIDTH-1:0] busOut,
  output logic [WIDTH-1:0] busOe,
  input wire logic readyIn,
  input wire logic acceptIn,
  output logic dataReady,
  output logic dataAccept,
  output bus_data_pkg::gpa_evoke_t gpaEvoke,
  input wire logic overflowIn,
  output logic carryGate,
  output logic donePulse,
  output bus_data_pkg::cond_t condMux,
  output logic linkOut,
  input wire logic [WIDTH-1:0] ioInPins,
  output logic [WIDTH-1:0] ioOutData,
  output logic ioOutStrobe,
  input wire logic startSwitch,
  output logic powerClear,
  output logic startPulse,
  input wire logic [3:0] regAddr,
  input wire logic [WIDTH-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [WIDTH-1:0] regRdata
);
  localparam int HB = WIDTH / 2;

  // Refused while elaborating, before any clock runs
  if (WIDTH < 2 || WIDTH % 2 != 0) begin : g_bad_width
    $error("WIDTH must be even and at least 2");
  end
  if (PWR_CLR_CYCLES < 1) begin : g_bad_pwr
    $error("PWR_CLR_CYCLES must be at least 1");
  end

  // Ops where the zero gate is the source and nothing drives the bus
  function automatic logic zeroGateOp(input bus_data_pkg::op_t op);
    case (op)
      bus_data_pkg::OP_CLEAR_ACC, bus_data_pkg::OP_CLEAR_ARG,
      bus_data_pkg::OP_CLEAR_HOLD, bus_data_pkg::OP_BANK_HALT,
      bus_data_pkg::OP_FLAG_CMD, bus_data_pkg::OP_LINK_LOAD,
      bus_data_pkg::OP_LINK_CLEAR, bus_data_pkg::OP_LINK_SET,
      bus_data_pkg::OP_LINK_INVERT: zeroGateOp = 1'b1;
      default: zeroGateOp = 1'b0;
    endcase
  endfunction

  logic [WIDTH-1:0] holdQ;
  logic [WIDTH-1:0] constQ [4];
  logic autoStartQ;
  logic [WIDTH-1:0] ioOutQ;
  logic [WIDTH-1:0] ioSync1Q;
  logic [WIDTH-1:0] ioSync2Q;
  logic negQ;
  logic zeroQ;
  logic posQ;
  logic carryQ;
  logic linkQ;
  logic doneQ;
  logic donePulseQ;
  logic ioStrobeQ;
  logic [WIDTH-1:0] rdataQ;

  logic ownReady;
  logic ownAccept;
  logic [WIDTH-1:0] ownDrive;
  logic active;
  logic fire;
  logic [WIDTH-1:0] busValue;

  // Source, destination and gate decode per evoke
  always_comb begin
    ownReady = 1'b0;
    ownAccept = 1'b0;
    ownDrive = '0;
    gpaEvoke = '0;
    case (evoke.op)
      bus_data_pkg::OP_HOLD_W_FROM_ACC, bus_data_pkg::OP_HOLD_U_FROM_ACC,
      bus_data_pkg::OP_HOLD_L_FROM_ACC: begin
        gpaEvoke.accSrc = 1'b1; // RULE1
        ownAccept = 1'b1; // RULE3
      end
      bus_data_pkg::OP_ACC_FROM_HOLD_W: begin
        ownReady = 1'b1;
        ownDrive = holdQ; // RULE1
        gpaEvoke.accDst = 1'b1; // RULE2
      end
      bus_data_pkg::OP_ACC_FROM_HOLD_U: begin
        ownReady = 1'b1;
        ownDrive = {holdQ[WIDTH-1:HB], {HB{1'b0}}}; // RULE1
        gpaEvoke.accDst = 1'b1; // RULE2
      end
      bus_data_pkg::OP_ACC_FROM_HOLD_L: begin
        ownReady = 1'b1;
        ownDrive = {{HB{1'b0}}, holdQ[HB-1:0]}; // RULE1
        gpaEvoke.accDst = 1'b1; // RULE2
      end
      bus_data_pkg::OP_ARG_FROM_CONST: begin
        ownReady = 1'b1;
        ownDrive = constQ[evoke.constSel]; // RULE4
        gpaEvoke.argDst = 1'b1; // RULE5
      end
      bus_data_pkg::OP_IO_FROM_ACC: begin
        gpaEvoke.accSrc = 1'b1; // RULE6
        ownAccept = 1'b1;
      end
      bus_data_pkg::OP_IO_FROM_ARG: begin
        gpaEvoke.argSrc = 1'b1; // RULE6
        ownAccept = 1'b1;
      end
      bus_data_pkg::OP_ACC_FROM_IO: begin
        ownReady = 1'b1;
        ownDrive = ioSync2Q; // RULE6
        gpaEvoke.accDst = 1'b1;
      end
      bus_data_pkg::OP_ARG_FROM_IO: begin
        ownReady = 1'b1;
        ownDrive = ioSync2Q; // RULE6
        gpaEvoke.argDst = 1'b1;
      end
      bus_data_pkg::OP_EXAMINE_ACC: begin
        gpaEvoke.accSrc = 1'b1;
        ownAccept = 1'b1; // RULE13
      end
      bus_data_pkg::OP_EXAMINE_ARG: begin
        gpaEvoke.argSrc = 1'b1;
        ownAccept = 1'b1; // RULE13
      end
      bus_data_pkg::OP_CLEAR_ACC: begin
        ownReady = 1'b1; // RULE16
        gpaEvoke.accDst = 1'b1;
      end
      bus_data_pkg::OP_CLEAR_ARG: begin
        ownReady = 1'b1; // RULE16
        gpaEvoke.argDst = 1'b1;
      end
      bus_data_pkg::OP_CLEAR_HOLD: begin
        ownReady = 1'b1; // RULE16
        ownAccept = 1'b1;
      end
      bus_data_pkg::OP_BANK_HALT: begin
        ownReady = 1'b1; // RULE17
        ownAccept = 1'b1;
      end
      // Accept comes from the outside flag module
      bus_data_pkg::OP_FLAG_CMD: begin
        ownReady = 1'b1; // RULE17
      end
      // Link lives here, so this end accepts for link commands
      bus_data_pkg::OP_LINK_LOAD, bus_data_pkg::OP_LINK_CLEAR,
      bus_data_pkg::OP_LINK_SET, bus_data_pkg::OP_LINK_INVERT: begin
        ownReady = 1'b1; // RULE17
        ownAccept = 1'b1;
      end
      default: begin
      end
    endcase
  end

  assign active = evoke.op != bus_data_pkg::OP_IDLE;
  assign dataReady = ownReady;
  assign dataAccept = ownAccept;
  // Once per evoke: doneQ blocks a second capture while op still held
  assign fire = active && !doneQ && (ownReady || readyIn) && (ownAccept || acceptIn); // RULE21
  assign busValue = ownDrive | ~busLevel; // RULE23
  assign busOut = '0;
  assign busOe = ownDrive; // RULE7
  assign carryGate = active && evoke.save; // RULE14

  always_ff @(posedge core_clk) begin
    if (rst) begin
      doneQ <= 1'b0;
    end else if (!active) begin
      doneQ <= 1'b0;
    end else if (fire) begin
      doneQ <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      donePulseQ <= 1'b0;
    end else begin
      donePulseQ <= fire; // RULE18
    end
  end
  assign donePulse = donePulseQ;

  // Every completed transfer rewrites the sign flags
  always_ff @(posedge core_clk) begin
    if (rst) begin
      negQ <= 1'b0;
      zeroQ <= 1'b0;
      posQ <= 1'b0;
    end else if (fire) begin
      negQ <= busValue[WIDTH-1]; // RULE8 RULE9
      zeroQ <= busValue == '0; // RULE10 RULE17
      posQ <= !busValue[WIDTH-1] && busValue != '0; // RULE11
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      carryQ <= 1'b0;
    end else if (fire && evoke.save) begin
      carryQ <= overflowIn; // RULE14
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      linkQ <= 1'b0;
    end else if (fire) begin
      case (evoke.op)
        bus_data_pkg::OP_LINK_LOAD: linkQ <= carryQ; // RULE15
        bus_data_pkg::OP_LINK_CLEAR: linkQ <= 1'b0; // RULE22
        bus_data_pkg::OP_LINK_SET: linkQ <= 1'b1; // RULE22
        bus_data_pkg::OP_LINK_INVERT: linkQ <= !linkQ; // RULE22
        default: linkQ <= linkQ;
      endcase
    end
  end
  assign linkOut = linkQ;
  assign condMux = '{negative: negQ, zero: zeroQ, positive: posQ, carry: carryQ}; // RULE12

  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdQ <= '0;
    end else if (fire) begin
      case (evoke.op)
        bus_data_pkg::OP_HOLD_W_FROM_ACC: holdQ <= busValue; // RULE1
        bus_data_pkg::OP_HOLD_U_FROM_ACC: holdQ[WIDTH-1:HB] <= busValue[WIDTH-1:HB];
        bus_data_pkg::OP_HOLD_L_FROM_ACC: holdQ[HB-1:0] <= busValue[HB-1:0];
        bus_data_pkg::OP_CLEAR_HOLD: holdQ <= busValue; // RULE16
        default: holdQ <= holdQ;
      endcase
    end
  end

  // Outside-world pins cross two flops before use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ioSync1Q <= '0;
      ioSync2Q <= '0;
    end else begin
      ioSync1Q <= ioInPins;
      ioSync2Q <= ioSync1Q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ioOutQ <= '0;
      ioStrobeQ <= 1'b0;
    end else begin
      ioStrobeQ <= fire && (evoke.op == bus_data_pkg::OP_IO_FROM_ACC ||
                            evoke.op == bus_data_pkg::OP_IO_FROM_ARG);
      if (fire && (evoke.op == bus_data_pkg::OP_IO_FROM_ACC ||
                   evoke.op == bus_data_pkg::OP_IO_FROM_ARG)) begin
        ioOutQ <= busValue; // RULE6
      end
    end
  end
  assign ioOutData = ioOutQ;
  assign ioOutStrobe = ioStrobeQ;

  // Power clear and start
  logic [$clog2(PWR_CLR_CYCLES+1)-1:0] pwrCntQ;
  logic pwrClrQ;
  logic pwrDoneQ;
  logic sw1Q;
  logic sw2Q;
  logic sw3Q;
  logic startQ;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwrCntQ <= '0;
      pwrClrQ <= 1'b1;
      pwrDoneQ <= 1'b0;
    end else if (pwrClrQ) begin
      pwrCntQ <= pwrCntQ + 1'b1;
      if (pwrCntQ == $bits(pwrCntQ)'(PWR_CLR_CYCLES - 1)) begin
        pwrClrQ <= 1'b0; // RULE19
        pwrDoneQ <= 1'b1;
      end
    end else begin
      pwrDoneQ <= 1'b0;
    end
  end
  assign powerClear = pwrClrQ;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sw1Q <= 1'b0;
      sw2Q <= 1'b0;
      sw3Q <= 1'b0;
    end else begin
      sw1Q <= startSwitch;
      sw2Q <= sw1Q;
      sw3Q <= sw2Q;
    end
  end

  // Switch ignored while power clear holds the machine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      startQ <= 1'b0;
    end else begin
      startQ <= (pwrDoneQ && autoStartQ) ||
                (!pwrClrQ && !autoStartQ && sw2Q && !sw3Q); // RULE19
    end
  end
  assign startPulse = startQ;

  // Register port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      autoStartQ <= `AUTOSTART_RST;
    end else if (regWr && regAddr == `REG_CTRL) begin
      autoStartQ <= regWdata[`CTRL_AUTOSTART];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_const
      always_ff @(posedge core_clk) begin
        if (rst) begin
          constQ[gi] <= WIDTH'(`CONST_RST);
        end else if (regWr && regAddr == `REG_CONST0 + 4'(gi)) begin
          constQ[gi] <= regWdata; // RULE4
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdataQ <= '0;
    end else if (regRd) begin
      rdataQ <= '0;
      case (regAddr)
        `REG_CTRL: rdataQ[`CTRL_AUTOSTART] <= autoStartQ;
        `REG_CONST0, `REG_CONST0 + 4'h1, `REG_CONST0 + 4'h2, `REG_CONST0 + 4'h3:
          rdataQ <= constQ[2'(regAddr - `REG_CONST0)];
        `REG_STATUS: begin
          rdataQ[`STAT_NEG] <= negQ;
          rdataQ[`STAT_ZERO] <= zeroQ;
          rdataQ[`STAT_POS] <= posQ;
          rdataQ[`STAT_CARRY] <= carryQ;
          rdataQ[`STAT_LINK] <= linkQ;
        end
        `REG_HOLD: rdataQ <= holdQ;
        `REG_IO_OUT: rdataQ <= ioOutQ;
        default: rdataQ <= '0;
      endcase
    end else begin
      rdataQ <= '0;
    end
  end
  assign regRdata = rdataQ;

  a_done_follows: assert property (@(posedge core_clk) disable iff (rst) // RULE18
    fire |=> donePulse ##1 !donePulse) else $error("completion pulse wrong");
  a_neg_capture: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    fire |=> negQ == $past(busValue[WIDTH-1])) else $error("negative flag wrong");
  a_zero_capture: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    fire |=> zeroQ == ($past(busValue) == '0)) else $error("zero flag wrong");
  a_pos_exclusive: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    donePulse |-> posQ == (!negQ && !zeroQ)) else $error("positive flag wrong");
  a_no_half: assert property (@(posedge core_clk) disable iff (rst) // RULE21
    !((ownReady || readyIn) && (ownAccept || acceptIn)) |=> $stable({negQ, zeroQ, posQ}))
    else $error("flags moved without handshake");
  a_carry_save: assert property (@(posedge core_clk) disable iff (rst) // RULE14
    fire && evoke.save |=> carryQ == $past(overflowIn)) else $error("carry not saved");
  a_zero_gate: assert property (@(posedge core_clk) disable iff (rst) // RULE16
    zeroGateOp(evoke.op) |-> ownReady && busOe == '0) else $error("zero gate drives bus");
  a_const_src: assert property (@(posedge core_clk) disable iff (rst) // RULE5
    evoke.op == bus_data_pkg::OP_ARG_FROM_CONST |-> !ownAccept && gpaEvoke == 4'b0001)
    else $error("constant routed wrongly");
  a_hold_to_acc: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    evoke.op inside {bus_data_pkg::OP_ACC_FROM_HOLD_W, bus_data_pkg::OP_ACC_FROM_HOLD_U,
    bus_data_pkg::OP_ACC_FROM_HOLD_L} |-> gpaEvoke == 4'b0010)
    else $error("holding to argument");
  a_link_invert: assert property (@(posedge core_clk) disable iff (rst) // RULE22
    fire && evoke.op == bus_data_pkg::OP_LINK_INVERT |=> linkQ != $past(linkQ))
    else $error("link not inverted");
  a_io_strobe: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    fire && evoke.op inside {bus_data_pkg::OP_IO_FROM_ACC, bus_data_pkg::OP_IO_FROM_ARG}
    |=> ioOutStrobe && ioOutData == $past(busValue)) else $error("io port not loaded");
  a_power_clear: assert property (@(posedge core_clk) // RULE19
    $fell(rst) |-> powerClear [*2]) else $error("power clear missing");
endmodule
`default_nettype wire

// ---- verif/arith_partner.sv ----
// Arithmetic unit model: accumulator and argument registers on the bus
`timescale 1ns/1ns
`default_nettype none
module arith_partner (
  input wire logic core_clk,
  input wire bus_data_pkg::gpa_evoke_t gpaEvoke,
  input wire logic [15:0] busVal,
  input wire logic readyAll,
  input wire logic flagAccept,
  input wire logic preset,
  input wire logic [15:0] presetVal,
  output logic [15:0] drive,
  output logic readyIn,
  output logic acceptIn,
  output logic [15:0] acc,
  output logic [15:0] arg
);
  assign readyIn = gpaEvoke.accSrc | gpaEvoke.argSrc;
  // Flag module accept is folded in here to save a port on the bench
  assign acceptIn = gpaEvoke.accDst | gpaEvoke.argDst | flagAccept;
  assign drive = gpaEvoke.accSrc ? acc : (gpaEvoke.argSrc ? arg : 16'h0000);
  always_ff @(posedge core_clk) begin
    if (preset) begin
      acc <= presetVal;
      arg <= presetVal;
    end else if (readyAll) begin
      if (gpaEvoke.accDst) acc <= busVal;
      if (gpaEvoke.argDst) arg <= busVal;
    end
  end
endmodule
`default_nettype wire

// ---- verif/test_bus_data_modules.sv ----
// Self-checking bench for the bus data modules
`include "bus_data_map.svh"
`timescale 1ns/1ns
`default_nettype none
module test_bus_data_modules;
  localparam int PWR = 4;
  logic core_clk = 1'b0, rst = 1'b1, readyIn, acceptIn, dataReady, dataAccept;
  logic overflowIn = 1'b0, carryGate, donePulse, linkOut, ioOutStrobe;
  logic startSwitch = 1'b0, powerClear, startPulse, regWr = 1'b0, regRd = 1'b0;
  logic flagAccept = 1'b0, preset = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] busLevel, busOut, busOe, ioOutData, regRdata, pDrive, acc, arg;
  logic [15:0] regWdata = 16'h0000, ioInPins = 16'h0000, presetVal = 16'h0000;
  bus_data_pkg::evoke_t evoke = '0;
  bus_data_pkg::gpa_evoke_t gpaEvoke;
  bus_data_pkg::cond_t condMux;
  int mismatches = 0, checksDone = 0;
  // Pull-up bus: any open-collector driver pulls the line low
  assign busLevel = ~(busOe | pDrive);
  bus_data_modules #(.WIDTH(16), .PWR_CLR_CYCLES(PWR)) i_bus_data_modules (
    .core_clk(core_clk), .rst(rst), .evoke(evoke), .busLevel(busLevel), .busOut(busOut),
    .busOe(busOe), .readyIn(readyIn), .acceptIn(acceptIn), .dataReady(dataReady),
    .dataAccept(dataAccept), .gpaEvoke(gpaEvoke), .overflowIn(overflowIn),
    .carryGate(carryGate), .donePulse(donePulse), .condMux(condMux), .linkOut(linkOut),
    .ioInPins(ioInPins), .ioOutData(ioOutData), .ioOutStrobe(ioOutStrobe),
    .startSwitch(startSwitch), .powerClear(powerClear), .startPulse(startPulse),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  arith_partner i_arith_partner (.core_clk(core_clk), .gpaEvoke(gpaEvoke),
    .busVal(~busLevel), .readyAll(readyIn | dataReady), .flagAccept(flagAccept),
    .preset(preset), .presetVal(presetVal), .drive(pDrive), .readyIn(readyIn),
    .acceptIn(acceptIn), .acc(acc), .arg(arg));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic flags(logic [15:0] v);
    logic n, z;
    n = v[15];
    z = (v == 16'h0000);
    chk("flags", {13'h0, n, z, !n && !z}, {13'h0, condMux.negative, condMux.zero,
      condMux.positive});
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    @(posedge core_clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk("regRdata", exp, regRdata);
  endtask
  task automatic setAB(logic [15:0] v);
    @(posedge core_clk);
    preset <= 1'b1; presetVal <= v;
    @(posedge core_clk);
    preset <= 1'b0;
  endtask
  // One transfer: hold the evoke until completion, then one idle cycle
  task automatic run(bus_data_pkg::op_t op, logic [1:0] sel, logic sv);
    int n;
    @(posedge core_clk);
    evoke <= '{op: op, constSel: sel, save: sv};
    @(negedge core_clk);
    chk("carryGate", {15'h0, sv}, {15'h0, carryGate});
    n = 0;
    while (donePulse !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk("donePulse", 16'h0001, {15'h0, donePulse});
    @(posedge core_clk);
    evoke <= '{op: bus_data_pkg::OP_IDLE, constSel: 2'h0, save: 1'b0};
    @(negedge core_clk);
    chk("donePulseEnd", 16'h0000, {15'h0, donePulse});
  endtask
  task automatic waitStart();
    int n;
    n = 0;
    while (startPulse !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    chk("startPulse", 16'h0001, {15'h0, startPulse});
  endtask
  task automatic t_power();
    int n;
    repeat (15) @(posedge core_clk);
    @(negedge core_clk);
    chk("powerClear", 16'h0001, {15'h0, powerClear});
    @(posedge core_clk);
    rst <= 1'b0;
    n = 0;
    while (powerClear !== 1'b0 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk("powerClearLen", 16'h0001, {15'h0, n >= PWR && n <= PWR + 2});
    waitStart();
    wr(`REG_CTRL, 16'h0000);
    @(posedge core_clk);
    startSwitch <= 1'b1;
    waitStart();
    @(posedge core_clk);
    startSwitch <= 1'b0;
  endtask
  task automatic t_regs();
    rd(`REG_CONST0, `CONST_RST);
    rd(4'hF, 16'h0000);
  endtask
  task automatic t_hold();
    setAB(16'hA5C3);
    run(bus_data_pkg::OP_HOLD_W_FROM_ACC, 2'h0, 1'b0);
    flags(16'hA5C3);
    rd(`REG_HOLD, 16'hA5C3);
    setAB(16'h1234);
    run(bus_data_pkg::OP_HOLD_U_FROM_ACC, 2'h0, 1'b0);
    setAB(16'h5678);
    run(bus_data_pkg::OP_HOLD_L_FROM_ACC, 2'h0, 1'b0);
    rd(`REG_HOLD, 16'h1278);
    run(bus_data_pkg::OP_ACC_FROM_HOLD_L, 2'h0, 1'b0);
    chk("acc", 16'h0078, acc);
    chk("arg", 16'h5678, arg);
    run(bus_data_pkg::OP_ACC_FROM_HOLD_U, 2'h0, 1'b0);
    chk("acc", 16'h1200, acc);
    flags(16'h1200);
    run(bus_data_pkg::OP_ACC_FROM_HOLD_W, 2'h0, 1'b0);
    chk("acc", 16'h1278, acc);
  endtask
  task automatic t_const();
    logic [15:0] k [4] = '{16'h8001, 16'h0000, 16'h7FFE, 16'hFFFF};
    setAB(16'h4444);
    for (int i = 0; i < 4; i++) begin
      wr(`REG_CONST0 + 4'(i), k[i]);
      run(bus_data_pkg::OP_ARG_FROM_CONST, 2'(i), 1'b0);
      chk("arg", k[i], arg);
      chk("acc", 16'h4444, acc);
      flags(k[i]);
    end
  endtask
  task automatic t_io();
    @(posedge core_clk);
    ioInPins <= 16'h8000;
    setAB(16'h3C3C);
    run(bus_data_pkg::OP_ACC_FROM_IO, 2'h0, 1'b0);
    chk("acc", 16'h8000, acc);
    run(bus_data_pkg::OP_IO_FROM_ARG, 2'h0, 1'b0);
    chk("ioOut", 16'h3C3C, ioOutData);
    run(bus_data_pkg::OP_IO_FROM_ACC, 2'h0, 1'b0);
    chk("ioOut", 16'h8000, ioOutData);
    // Pins need two edges through the synchroniser before the transfer
    @(posedge core_clk);
    ioInPins <= 16'h0000;
    repeat (2) @(posedge core_clk);
    run(bus_data_pkg::OP_ARG_FROM_IO, 2'h0, 1'b0);
    chk("arg", 16'h0000, arg);
    flags(16'h0000);
  endtask
  task automatic t_carry();
    setAB(16'h0001);
    overflowIn <= 1'b1;
    run(bus_data_pkg::OP_EXAMINE_ACC, 2'h0, 1'b1);
    flags(16'h0001);
    chk("carry", 16'h0001, {15'h0, condMux.carry});
    @(posedge core_clk);
    overflowIn <= 1'b0;
    run(bus_data_pkg::OP_LINK_LOAD, 2'h0, 1'b0);
    chk("link", 16'h0001, {15'h0, linkOut});
    run(bus_data_pkg::OP_LINK_INVERT, 2'h0, 1'b0);
    chk("link", 16'h0000, {15'h0, linkOut});
    run(bus_data_pkg::OP_LINK_SET, 2'h0, 1'b0);
    rd(`REG_STATUS, 16'h001A);
    run(bus_data_pkg::OP_EXAMINE_ARG, 2'h0, 1'b1);
    run(bus_data_pkg::OP_LINK_CLEAR, 2'h0, 1'b0);
    rd(`REG_STATUS, 16'h0002);
  endtask
  task automatic t_clear();
    setAB(16'hFFFF);
    run(bus_data_pkg::OP_CLEAR_ACC, 2'h0, 1'b0);
    chk("acc", 16'h0000, acc);
    run(bus_data_pkg::OP_CLEAR_HOLD, 2'h0, 1'b0);
    rd(`REG_HOLD, 16'h0000);
    run(bus_data_pkg::OP_EXAMINE_ARG, 2'h0, 1'b0);
    flags(16'hFFFF);
    chk("acc", 16'h0000, acc);
    run(bus_data_pkg::OP_BANK_HALT, 2'h0, 1'b0);
    flags(16'h0000);
    run(bus_data_pkg::OP_EXAMINE_ARG, 2'h0, 1'b0);
    flags(16'hFFFF);
    run(bus_data_pkg::OP_CLEAR_ARG, 2'h0, 1'b0);
    chk("arg", 16'h0000, arg);
    setAB(16'h8000);
    flagAccept <= 1'b1;
    run(bus_data_pkg::OP_FLAG_CMD, 2'h0, 1'b0);
    flags(16'h0000);
    chk("acc", 16'h8000, acc);
    @(posedge core_clk);
    flagAccept <= 1'b0;
  endtask
  // Who raises ready and accept while a transfer is held
  task automatic t_roles();
    @(posedge core_clk);
    evoke <= '{op: bus_data_pkg::OP_ARG_FROM_CONST, constSel: 2'h0, save: 1'b0};
    @(negedge core_clk);
    chk("roleConst", 16'h0021, {10'h0, dataReady, dataAccept, gpaEvoke});
    chk("busOe", 16'h8001, busOe);
    chk("busOut", 16'h0000, busOut);
    @(posedge core_clk);
    evoke <= '0;
    @(posedge core_clk);
    evoke <= '{op: bus_data_pkg::OP_EXAMINE_ACC, constSel: 2'h0, save: 1'b0};
    @(negedge core_clk);
    chk("roleExamine", 16'h0018, {10'h0, dataReady, dataAccept, gpaEvoke});
    @(posedge core_clk);
    evoke <= '0;
    // No outside accept: the transfer must stay pending
    @(posedge core_clk);
    evoke <= '{op: bus_data_pkg::OP_FLAG_CMD, constSel: 2'h0, save: 1'b0};
    repeat (3) @(negedge core_clk);
    chk("roleFlag", 16'h0020, {10'h0, dataReady, dataAccept, gpaEvoke});
    chk("donePending", 16'h0000, {15'h0, donePulse});
    @(posedge core_clk);
    evoke <= '0;
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end
  initial begin
    t_power();
    t_regs();
    t_hold();
    t_const();
    t_io();
    t_carry();
    t_clear();
    t_roles();
    finish_test();
  end
endmodule
`default_nettype wire
